// [hsg_gate_ctrl.sv]
// module: gate enable control, straps, latch and supply-good logic
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Function
// - falling edge on restart turns gate off ten seconds, then back on.
// - gate stays off while shutdown input is held low.
// - retry scheme chosen from latch, shutdown, restart and pin b straps.
// - latched-off state after overcurrent fault shows on latch pin.
// - fault timer over upper threshold turns the gate off.
// - address strap decodes to one of four bus addresses.
// - multi-function pins selectable as general output or alert.
// - pin a as conversion input starts a sampling cycle on outside signal.
// - pin a shows transistor health by default after power-up.
// - pin b shows seven failed power-up attempts by default.
// - gate held off while supply is outside the voltage window.
// - supply-good output low while supply within limits.
module hsg_gate_ctrl
    import hsg_pkg::*;
#(
    parameter logic [cnt_w-1:0] restart_cycles = cnt_w'(restart_cycles_def)
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic shutdown_in_n,
    input wire logic restart_in_n,
    input wire logic latch_strap_in,
    input wire logic shutdown_strap_in,
    input wire logic restart_strap_in,
    input wire logic notify_b_strap_in,
    input wire logic overcurrent_in,
    input wire logic timer_over_cmp,
    input wire logic undervolt_rise_cmp,
    input wire logic undervolt_fall_cmp,
    input wire logic overvolt_cmp,
    input wire logic fet_healthy_in,
    input wire logic [7:0] fault_enable_in,
    input wire logic [7:0] fault_flags_in,
    input wire hsg_adr_t addr_strap_in,
    input wire hsg_mf_t mode_a_in,
    input wire hsg_mf_t mode_b_in,
    input wire logic gpo_a_in,
    input wire logic gpo_b_in,
    input wire logic sample_trigger_in,
    input wire logic latch_clear_in,
    output logic gate_enable_out,
    output logic latch_out,
    output logic supply_in_range_n,
    output logic [6:0] bus_addr_out,
    output hsg_retry_t retry_mode_out,
    output logic sample_start_out,
    output logic general_out_a,
    output logic general_out_b
);
    typedef enum logic [1:0] {
        hsg_st_strap,
        hsg_st_run,
        hsg_st_hold
    } hsg_state_t;

    hsg_state_t state;
    hsg_state_t next_state;
    logic [cnt_w-1:0] cnt;
    logic [cnt_w-1:0] next_cnt;
    logic restart_prev;
    logic next_restart_prev;
    logic latched;
    logic next_latched;
    logic [2:0] fails;
    logic [2:0] next_fails;
    logic in_range;
    logic next_in_range;
    logic gate;
    logic next_gate;
    hsg_retry_t retry;
    hsg_retry_t next_retry;
    logic [6:0] addr;
    logic [6:0] next_addr;
    logic restart_fall;
    logic fault_now;

    hsg_mf_if mf();

    function automatic logic [6:0] adr_decode(input hsg_adr_t s);
        return addr_base + 7'(s);
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // state and supply logic
    assign restart_fall = restart_prev && !restart_in_n;
    assign fault_now = overcurrent_in || timer_over_cmp;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_restart_prev = restart_in_n;
        next_latched = latched;
        next_fails = fails;
        next_retry = retry;
        next_addr = addr;
        // hysteresis: rising threshold to enter, falling threshold to leave
        next_in_range = in_range ? (undervolt_fall_cmp && !overvolt_cmp)
                                 : (undervolt_rise_cmp && !overvolt_cmp);
        unique case (state)
            hsg_st_strap: begin
                // straps sampled once after reset release, not during reset
                next_retry = hsg_retry_t'({latch_strap_in ^ notify_b_strap_in,
                                           shutdown_strap_in ^ restart_strap_in});
                next_addr = adr_decode(addr_strap_in);
                next_state = hsg_st_run;
            end
            hsg_st_run: begin
                if (restart_fall) begin
                    next_state = hsg_st_hold;
                    next_cnt = restart_cycles;
                end
            end
            hsg_st_hold: begin
                if (cnt == '0) begin
                    next_state = hsg_st_run;
                    next_latched = 1'b0;
                end else begin
                    next_cnt = cnt - cnt_w'(1);
                end
            end
            default: next_state = hsg_st_strap;
        endcase
        if (fault_now && gate) begin
            if (fails != fail_limit_3) begin
                next_fails = fails + 3'h1;
            end
            if (retry == hsg_retry_latch || fails == fail_limit_3 - 3'h1 || timer_over_cmp) begin
                next_latched = 1'b1;
            end
        end else if (latch_clear_in && !fault_now) begin
            next_latched = 1'b0;
            next_fails = fail_zero;
        end
        // next state, so the gate drops at the very edge that sees the restart fall
        next_gate = shutdown_in_n && (next_state == hsg_st_run) && next_in_range
                    && !next_latched && !timer_over_cmp;
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state <= hsg_st_strap;
            cnt <= '0;
            restart_prev <= 1'b1;
            latched <= 1'b0;
            fails <= fail_zero;
            in_range <= 1'b0;
            gate <= 1'b0;
            retry <= hsg_retry_latch;
            addr <= addr_base;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            restart_prev <= next_restart_prev;
            latched <= next_latched;
            fails <= next_fails;
            in_range <= next_in_range;
            gate <= next_gate;
            retry <= next_retry;
            addr <= next_addr;
        end
    end

    assign gate_enable_out = gate;
    assign latch_out = latched;
    assign supply_in_range_n = !in_range;
    assign bus_addr_out = addr;
    assign retry_mode_out = retry;

    //////////////////////////////////////////////////////////////////////////
    // multi-function pins
    assign mf.fet_healthy = fet_healthy_in;
    assign mf.seven_fail = (fails == fail_limit_3);
    assign mf.any_alert = |(fault_enable_in & fault_flags_in);
    assign sample_start_out = mf.sample_start;

    hsg_mf_pins u_mf (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .mf(mf),
        .mode_a_in(mode_a_in),
        .mode_b_in(mode_b_in),
        .gpo_a_in(gpo_a_in),
        .gpo_b_in(gpo_b_in),
        .sample_trigger_in(sample_trigger_in),
        .pin_a_out(general_out_a),
        .pin_b_out(general_out_b)
    );
endmodule

// [hsg_pkg.sv]
// package: constants and types for the hot swap gate pin control block
package hsg_pkg;
    localparam int unsigned clk_mhz = 200;
    localparam int unsigned restart_off_sec = 10;
    // restart hold-off in cycles: 10 s at 200 MHz
    localparam longint unsigned restart_cycles_def = longint'(restart_off_sec) * 64'd1000000 * longint'(clk_mhz);
    localparam int cnt_w = 32;
    localparam int unsigned fail_limit = 7;
    localparam logic [2:0] fail_limit_3 = 3'h7;
    localparam logic [2:0] fail_zero = 3'h0;
    localparam logic [6:0] addr_base = 7'h10;
    // address strap codes as sensed by the pad level detector
    typedef enum logic [1:0] {
        hsg_adr_low,
        hsg_adr_res,
        hsg_adr_float,
        hsg_adr_reg
    } hsg_adr_t;
    // retry scheme chosen from the straps
    typedef enum logic [1:0] {
        hsg_retry_latch,
        hsg_retry_auto,
        hsg_retry_seven,
        hsg_retry_none
    } hsg_retry_t;
    // multi-function pin mode
    typedef enum logic [1:0] {
        hsg_mf_default,
        hsg_mf_gpo,
        hsg_mf_alert,
        hsg_mf_sample_trigger_in
    } hsg_mf_t;
endpackage

// [hsg_mf_if.sv]
// interface: signals between the gate core and the multi-function pin logic
`timescale 1ns/10ps
interface hsg_mf_if;
    import hsg_pkg::*;
    logic fet_healthy;
    logic seven_fail;
    logic any_alert;
    logic sample_start;
    modport core (output fet_healthy, output seven_fail, output any_alert, input sample_start);
    modport pins (input fet_healthy, input seven_fail, input any_alert, output sample_start);
endinterface

// [hsg_mf_pins.sv]
// module: multi-function output pins and conversion trigger input
`timescale 1ns/10ps
module hsg_mf_pins
    import hsg_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    hsg_mf_if.pins mf,
    input wire hsg_mf_t mode_a_in,
    input wire hsg_mf_t mode_b_in,
    input wire logic gpo_a_in,
    input wire logic gpo_b_in,
    input wire logic sample_trigger_in,
    output logic pin_a_out,
    output logic pin_b_out
);
    logic trig_prev;
    logic next_trig_prev;
    logic next_pin_a;
    logic next_pin_b;

    // pin a: health by default, gpo, alert, or driven low as conversion input
    always_comb begin
        next_trig_prev = sample_trigger_in;
        unique case (mode_a_in)
            hsg_mf_default: next_pin_a = mf.fet_healthy;
            hsg_mf_gpo: next_pin_a = gpo_a_in;
            hsg_mf_alert: next_pin_a = mf.any_alert;
            hsg_mf_sample_trigger_in: next_pin_a = 1'b0;
        endcase
        unique case (mode_b_in)
            hsg_mf_default: next_pin_b = mf.seven_fail;
            hsg_mf_gpo: next_pin_b = gpo_b_in;
            hsg_mf_alert: next_pin_b = mf.any_alert;
            hsg_mf_sample_trigger_in: next_pin_b = mf.seven_fail;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            trig_prev <= 1'b0;
            pin_a_out <= 1'b0;
            pin_b_out <= 1'b0;
        end else begin
            trig_prev <= next_trig_prev;
            pin_a_out <= next_pin_a;
            pin_b_out <= next_pin_b;
        end
    end

    // rising edge of the outside trigger starts one sampling cycle
    assign mf.sample_start = (mode_a_in == hsg_mf_sample_trigger_in) && sample_trigger_in && !trig_prev;
endmodule

// [hsg_supply_model.sv]
// supply monitor comparators seen by the gate block
`timescale 1ns/10ps
module hsg_supply_model (
    input wire logic [1:0] level_in,
    output logic rise_out,
    output logic fall_out,
    output logic over_out
);
    // level 0 under both, 1 between, 2 in window, 3 over
    assign rise_out = level_in >= 2'h2;
    assign fall_out = level_in != 2'h0;
    assign over_out = level_in == 2'h3;
endmodule

// [hsg_sva.sv]
// checker for the gate pin control ports
`timescale 1ns/10ps
module hsg_sva
    import hsg_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic shutdown_in_n,
    input wire logic restart_in_n,
    input wire logic timer_over_cmp,
    input wire logic overvolt_cmp,
    input wire logic gpo_a_in,
    input wire logic sample_trigger_in,
    input wire hsg_mf_t mode_a_in,
    input wire logic gate_enable_out,
    input wire logic latch_out,
    input wire logic supply_in_range_n,
    input wire logic [6:0] bus_addr_out,
    input wire logic sample_start_out,
    input wire logic general_out_a
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_fall;
        $fell(restart_in_n);
    endsequence
    a_shutdown_in_n_off: assert property (!shutdown_in_n |=> !gate_enable_out) else $error("gate on in shutdown");
    a_timer_off: assert property (timer_over_cmp |=> !gate_enable_out) else $error("gate on after timer");
    a_ov_range: assert property (overvolt_cmp |=> supply_in_range_n) else $error("in range while over");
    a_ov_gate: assert property (overvolt_cmp[*2] |=> !gate_enable_out) else $error("gate on while over");
    a_restart_hold: assert property (s_fall |=> !gate_enable_out[*8]) else $error("gate on in hold");
    a_latch_gate: assert property (latch_out |-> !gate_enable_out) else $error("gate on while latched");
    a_addr_base: assert property (bus_addr_out[6:2] == addr_base[6:2]) else $error("address off base");
    a_sample_trigger_in_start: assert property (sample_start_out == (mode_a_in == hsg_mf_sample_trigger_in && $rose(sample_trigger_in)))
        else $error("sample start wrong");
    a_gpo_pin: assert property (mode_a_in == hsg_mf_gpo |=> general_out_a == $past(gpo_a_in))
        else $error("pin a not gpo");
endmodule
bind hsg_gate_ctrl hsg_sva chk (.clk_in(clk_in), .reset_n_in(reset_n_in), .shutdown_in_n(shutdown_in_n),
    .restart_in_n(restart_in_n), .timer_over_cmp(timer_over_cmp), .overvolt_cmp(overvolt_cmp), .gpo_a_in(gpo_a_in),
    .sample_trigger_in(sample_trigger_in), .mode_a_in(mode_a_in), .gate_enable_out(gate_enable_out),
    .latch_out(latch_out), .supply_in_range_n(supply_in_range_n), .bus_addr_out(bus_addr_out),
    .sample_start_out(sample_start_out), .general_out_a(general_out_a));

// [hot_swap_gate_pin_control_tb.sv]
// testbench for the gate pin control block
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module hot_swap_gate_pin_control_tb;
    import hsg_pkg::*;
    logic clk_in = 0, reset_n_in = 0, sd = 1, rs = 1, ls = 0, rss = 0, oc = 0, tm = 0, fet = 1, ga = 0, gb = 0;
    logic tr = 0, clr = 0, ri, fa, ov, gate, lat, rng, st, pa, pb;
    logic [1:0] lvl = 0;
    logic [7:0] en = 0, fl = 0;
    logic [6:0] addr;
    hsg_adr_t adr = hsg_adr_low;
    hsg_mf_t ma = hsg_mf_default, mb = hsg_mf_default;
    hsg_retry_t rty;
    int num_errors = 0, tests_run = 0;
    always #2.5 clk_in = ~clk_in;
    hsg_supply_model SUP (.level_in(lvl), .rise_out(ri), .fall_out(fa), .over_out(ov));
    // short hold-off so the restart scenario stays brief
    hsg_gate_ctrl #(.restart_cycles(32'h14)) DUT (.clk_in(clk_in), .reset_n_in(reset_n_in), .shutdown_in_n(sd),
        .restart_in_n(rs), .latch_strap_in(ls), .shutdown_strap_in(1'b0), .restart_strap_in(rss),
        .notify_b_strap_in(1'b0), .overcurrent_in(oc), .timer_over_cmp(tm), .undervolt_rise_cmp(ri),
        .undervolt_fall_cmp(fa), .overvolt_cmp(ov), .fet_healthy_in(fet), .fault_enable_in(en),
        .fault_flags_in(fl), .addr_strap_in(adr), .mode_a_in(ma), .mode_b_in(mb), .gpo_a_in(ga), .gpo_b_in(gb),
        .sample_trigger_in(tr), .latch_clear_in(clr), .gate_enable_out(gate), .latch_out(lat),
        .supply_in_range_n(rng), .bus_addr_out(addr), .retry_mode_out(rty), .sample_start_out(st),
        .general_out_a(pa), .general_out_b(pb));
    ////////////////////////////////////////////////////////////
    task cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task t_reset(input int i);
        cyc(1);
        adr = hsg_adr_t'(i);
        {ls, rss} = 2'(i);
        lvl = 0;
        reset_n_in = 0;
        cyc(5);
        `CHK("gate", 1'b0, gate)
        reset_n_in = 1;
        cyc(3);
        `CHK("addr", addr_base + 7'(i), addr)
        `CHK("retry", hsg_retry_t'(i), rty)
        `CHK("pin b", 1'b0, pb)
    endtask
    task t_power;
        lvl = 2;
        cyc(3);
        `CHK("range", 1'b0, rng)
        `CHK("gate", 1'b1, gate)
        `CHK("pin a", 1'b1, pa)
        fet = 0;
        cyc(2);
        `CHK("pin a", 1'b0, pa)
        fet = 1;
        sd = 0;
        cyc(2);
        `CHK("gate", 1'b0, gate)
        sd = 1;
        cyc(2);
        `CHK("gate", 1'b1, gate)
    endtask
    task t_supply;
        lvl = 3;
        cyc(3);
        `CHK("gate", 1'b0, gate)
        `CHK("range", 1'b1, rng)
        lvl = 2;
        cyc(3);
        `CHK("gate", 1'b1, gate)
    endtask
    task t_restart;
        rs = 0;
        cyc(1);
        rs = 1;
        cyc(19);
        `CHK("gate", 1'b0, gate)
        cyc(6);
        `CHK("gate", 1'b1, gate)
    endtask
    // one cycle fault, then clear the latch once the fault is gone
    task t_fault(input logic t);
        {tm, oc} = {t, !t};
        cyc(1);
        {tm, oc} = 2'h0;
        cyc(2);
        `CHK("gate", 1'b0, gate)
        `CHK("latch", 1'b1, lat)
        clr = 1;
        cyc(1);
        clr = 0;
        cyc(3);
        `CHK("latch", 1'b0, lat)
        `CHK("gate", 1'b1, gate)
    endtask
    task t_mf;
        {ma, mb, ga, gb} = {hsg_mf_gpo, hsg_mf_gpo, 1'b1, 1'b1};
        cyc(2);
        `CHK("pin a", 1'b1, pa)
        `CHK("pin b", 1'b1, pb)
        gb = 0;
        {ma, mb, en, fl} = {hsg_mf_alert, hsg_mf_alert, 8'h05, 8'h04};
        cyc(2);
        `CHK("alert", 2'h3, {pa, pb})
        fl = 8'h02;
        cyc(2);
        `CHK("alert", 2'h0, {pa, pb})
        ma = hsg_mf_sample_trigger_in;
        cyc(1);
        tr = 1;
        #1 `CHK("start", 1'b1, st)
        cyc(1);
        `CHK("start", 1'b0, st)
        tr = 0;
    endtask
    task summarize;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        summarize;
    end
    initial begin
        for (int i = 3; i >= 0; i--)
            t_reset(i);
        t_power;
        t_supply;
        t_restart;
        t_fault(1'b1);
        t_fault(1'b0);
        t_mf;
        summarize;
    end
endmodule
